// >>> rtl/brake_seq_pkg.sv
package brake_seq_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] TERM_OFS = 8'h04;
  localparam logic [7:0] FREQ_OFS = 8'h08;
  localparam logic [7:0] CURR_OFS = 8'h0C;
  localparam logic [7:0] TIME_OFS = 8'h10;
  localparam logic [7:0] STOP_OFS = 8'h14;
  localparam logic [7:0] OVSP_OFS = 8'h18;
  localparam logic [7:0] STAT_OFS = 8'h1C;
  localparam logic [7:0] FLT_OFS = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ACCEL_LSB = 0;
  localparam int DCHK_POS = 4;
  localparam int OPM_LSB = 8;
  localparam int ENC_POS = 12;
  localparam int HI_LSB = 16;
  localparam int FLT_LSB = 8;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SEQ_MODE_FB = 4'h7;
  localparam logic [3:0] SEQ_MODE_NOFB = 4'h8;
  localparam logic [1:0] OPM_EXT = 2'h0;
  localparam logic [1:0] OPM_COMB1 = 2'h1;
  localparam logic [1:0] OPM_NET = 2'h2;
  localparam logic [7:0] IN_FUNC_FB = 8'h0F;
  localparam logic [7:0] OUT_FUNC_POS = 8'h14;
  localparam logic [7:0] OUT_FUNC_NEG = 8'h78;
  localparam logic [15:0] OVSP_OFF = 16'h270F;

  // ----------------------------------------------------------------
  // Values after reset (frequency 0.01 Hz, current 0.1 %, times ms)
  // ----------------------------------------------------------------
  localparam logic [15:0] REL_FREQ_RST = 16'h012C;
  localparam logic [15:0] ENG_FREQ_RST = 16'h0258;
  localparam logic [15:0] REL_CURR_RST = 16'h0514;
  localparam logic [15:0] DET_TIME_RST = 16'h012C;
  localparam logic [15:0] START_TIME_RST = 16'h012C;
  localparam logic [15:0] STOP_TIME_RST = 16'h012C;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_S = 2;
  localparam logic [15:0] TIMEOUT_MS = 16'(TIMEOUT_S * 1000);

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start_cmd;
    logic decel_active;
    logic motor_stopped;
    logic stall_active;
    logic decel_abnormal;
    logic auto_accel_active;
    logic jog;
    logic second_setting_select;
    logic third_setting_select;
    logic [15:0] speed_cmd;
    logic [15:0] out_freq;
    logic [15:0] det_freq;
    logic [15:0] out_current;
  } drive_status_s;

  typedef struct packed {
    logic freq_hold;
    logic output_enable;
    logic trip;
    logic sequence_active;
    logic auto_restart_enable;
    logic jog_accept;
    logic second_setting_accept;
    logic third_setting_accept;
  } drive_ctrl_s;

  typedef enum logic [1:0] {HT_IDLE, HT_BUSY, HT_NONSEQ, HT_SEQ} htrans_e;

endpackage

// >>> rtl/mechanical_brake_sequencer.sv
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
// How it works
// [R1] Sequence only in external, combined-1, network modes
// [R2] Sequence only with accel mode 7 or 8
// [R3] Input function 15 is brake feedback
// [R4] Output function 20 high-true, 120 low-true
// [R5] Release after frequency, current and detect time
// [R6] Mode 7 holds until start time after feedback
// [R7] Drop release request at engage frequency decelerating
// [R8] Mode 7 output off stop time after feedback off
// [R9] Mode 8 holds start time after release request
// [R10] Mode 8 output off stop time after request off
// [R11] Jog or setting select at stop bypasses sequence
// [R12] Jog and second select ignored during auto accel
// [R13] Any fault trips and drops release request; code ignores faults while in ST_BYPASS
// [R14] Overspeed fault when slip exceeds threshold unless 9999
// [R15] Abnormal deceleration fault when checking, not stalling
// [R16] Gravity drop fault: request active at stop
// [R17] Release timeout: no request 2 s after start
// [R18] Feedback-on timeout: no feedback 2 s after request
// [R19] Feedback lost while request asserted
// [R20] Feedback-off timeout: feedback stays 2 s after stop
// [R21] Overspeed check active outside sequence modes too
// [R22] No automatic restart while sequence mode selected
// [R23] Deceleration check select 0 never checks
// [R24] Release frequency accepted only not above engage
// [R25] Reset or trip returns to idle, request off
module mechanical_brake_sequencer
  import brake_seq_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire drive_status_s drive_in,
  input wire logic feedback_pin,
  output logic release_pin,
  output drive_ctrl_s drive_out
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_REL, ST_DETECT, ST_WAIT_FB, ST_START_HOLD,
    ST_RUN, ST_ENGAGE_WAIT, ST_STOP_HOLD, ST_BYPASS, ST_FAULT
  } seq_state_e;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0] accel_mode_r;
  logic decel_check_r;
  logic [1:0] op_mode_r;
  logic encoder_fb_r;
  logic [7:0] in_func_r;
  logic [7:0] out_func_r;
  logic [15:0] rel_freq_r;
  logic [15:0] eng_freq_r;
  logic [15:0] rel_curr_r;
  logic [15:0] det_time_r;
  logic [15:0] start_time_r;
  logic [15:0] stop_time_r;
  logic [15:0] ovsp_r;
  logic [6:0] fault_r;
  logic [6:0] fault_set;
  logic [6:0] fault_clr;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic acc;
  logic [2:0] fb_sync_r;
  logic fb_filt_r;
  logic fb;
  logic [31:0] presc_r;
  logic tick;
  logic [15:0] ms_r;
  seq_state_e state_r;
  seq_state_e state_nxt;
  logic release_r;
  logic seq_en;
  logic mode_fb;
  logic jog_q;
  logic second_q;
  logic bypass_req;
  logic [15:0] slip;
  logic any_fault;

  // Register decode used by the write path; the read mux decodes haddr itself
  function automatic logic is_mapped(input logic [7:0] a);
    return a inside {MODE_OFS, TERM_OFS, FREQ_OFS, CURR_OFS, TIME_OFS,
                     STOP_OFS, OVSP_OFS, STAT_OFS, FLT_OFS};
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Zero wait states: reads are prepared in the address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && hready && htrans[1];

  // Capture the address phase of a write for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= acc && hwrite && is_mapped(haddr);
      wr_addr_r <= haddr;
    end
  end

  // Configuration registers, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accel_mode_r <= 4'h0;
      decel_check_r <= 1'b0;
      op_mode_r <= OPM_EXT;
      encoder_fb_r <= 1'b0;
      in_func_r <= 8'h00;
      out_func_r <= 8'h00;
      rel_freq_r <= REL_FREQ_RST;
      eng_freq_r <= ENG_FREQ_RST;
      rel_curr_r <= REL_CURR_RST;
      det_time_r <= DET_TIME_RST;
      start_time_r <= START_TIME_RST;
      stop_time_r <= STOP_TIME_RST;
      ovsp_r <= OVSP_OFF;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        MODE_OFS: begin
          accel_mode_r <= hwdata[ACCEL_LSB +: 4];
          decel_check_r <= hwdata[DCHK_POS];
          op_mode_r <= hwdata[OPM_LSB +: 2];
          encoder_fb_r <= hwdata[ENC_POS];
        end
        TERM_OFS: begin
          in_func_r <= hwdata[7:0];
          out_func_r <= hwdata[HI_LSB +: 8];
        end
        FREQ_OFS: begin
          // A pair with release above engage is refused whole
          if (hwdata[15:0] <= hwdata[HI_LSB +: 16]) begin // see [R24]
            rel_freq_r <= hwdata[15:0];
            eng_freq_r <= hwdata[HI_LSB +: 16];
          end
        end
        CURR_OFS: rel_curr_r <= hwdata[15:0];
        TIME_OFS: begin
          det_time_r <= hwdata[15:0];
          start_time_r <= hwdata[HI_LSB +: 16];
        end
        STOP_OFS: stop_time_r <= hwdata[15:0];
        OVSP_OFS: ovsp_r <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      unique case (haddr)
        MODE_OFS: hrdata <= {19'h0, encoder_fb_r, 2'h0, op_mode_r, 3'h0,
                             decel_check_r, accel_mode_r};
        TERM_OFS: hrdata <= {8'h00, out_func_r, 8'h00, in_func_r};
        FREQ_OFS: hrdata <= {eng_freq_r, rel_freq_r};
        CURR_OFS: hrdata <= {16'h0000, rel_curr_r};
        TIME_OFS: hrdata <= {start_time_r, det_time_r};
        STOP_OFS: hrdata <= {16'h0000, stop_time_r};
        OVSP_OFS: hrdata <= {16'h0000, ovsp_r};
        STAT_OFS: hrdata <= {17'h0, fault_r, 2'h0, seq_en, drive_out.trip,
                             drive_out.output_enable, drive_out.freq_hold,
                             fb, release_r};
        FLT_OFS: hrdata <= {17'h0, fault_r, 8'h00};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Feedback pin and enables
  // ----------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_sync_r <= 3'b000;
      fb_filt_r <= 1'b0;
    end else begin
      fb_sync_r <= {fb_sync_r[1:0], feedback_pin};
      if (fb_sync_r[1] == fb_sync_r[2]) begin
        fb_filt_r <= fb_sync_r[2];
      end
    end
  end

  // Feedback only exists when the input terminal is assigned to it
  assign fb = (in_func_r == IN_FUNC_FB) && fb_filt_r; // see [R3]
  assign seq_en = (op_mode_r inside {OPM_EXT, OPM_COMB1, OPM_NET}) // see [R1]
                  && (accel_mode_r inside {SEQ_MODE_FB, SEQ_MODE_NOFB}); // see [R2]
  assign mode_fb = (accel_mode_r == SEQ_MODE_FB);
  // Jog and second select are blind while auto accel runs
  assign jog_q = drive_in.jog && !drive_in.auto_accel_active; // see [R12]
  assign second_q = drive_in.second_setting_select && !drive_in.auto_accel_active; // see [R12]
  assign bypass_req = jog_q || second_q || drive_in.third_setting_select;

  // ----------------------------------------------------------------
  // Millisecond timer, restarted on every state change
  // ----------------------------------------------------------------
  assign tick = (presc_r == MS_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_r <= 32'h0000_0000;
    end else if (state_nxt != state_r || tick) begin
      presc_r <= 32'h0000_0000;
    end else begin
      presc_r <= presc_r + 32'h0000_0001;
    end
  end

  // Saturates so long waits never wrap into a false elapse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_r <= 16'h0000;
    end else if (state_nxt != state_r) begin
      ms_r <= 16'h0000;
    end else if (tick && ms_r != 16'hFFFF) begin
      ms_r <= ms_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  assign slip = drive_in.det_freq - drive_in.out_freq;

  always_comb begin
    fault_set = 7'h00;
    // Overspeed watches encoder runs whatever the accel mode
    fault_set[0] = encoder_fb_r && ovsp_r != OVSP_OFF // see [R14]
                   && drive_in.det_freq > drive_in.out_freq
                   && slip > ovsp_r; // see [R21]
    // Stall prevention periods are excused from the decel check
    fault_set[1] = decel_check_r && state_r == ST_RUN // see [R15]
                   && drive_in.decel_active && drive_in.decel_abnormal
                   && !drive_in.stall_active; // see [R23]
    fault_set[2] = release_r && drive_in.motor_stopped; // see [R16]
    fault_set[3] = state_r inside {ST_WAIT_REL, ST_DETECT} // see [R17]
                   && tick && ms_r >= TIMEOUT_MS;
    fault_set[4] = state_r == ST_WAIT_FB && tick && ms_r >= TIMEOUT_MS; // see [R18]
    fault_set[5] = mode_fb && release_r && !fb // see [R19]
                   && state_r inside {ST_START_HOLD, ST_RUN};
    fault_set[6] = state_r == ST_ENGAGE_WAIT && tick && ms_r >= TIMEOUT_MS; // see [R20]
    if (!seq_en) begin
      fault_set[6:1] = 6'h00;
    end
  end

  assign fault_clr = (wr_pend_r && wr_addr_r == FLT_OFS) ? hwdata[FLT_LSB +: 7] : 7'h00;

  // Write one to clear; a fault arriving the same cycle is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_r <= 7'h00;
    end else begin
      fault_r <= (fault_r & ~fault_clr) | fault_set;
    end
  end

  assign any_fault = |fault_set;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (bypass_req) begin
          state_nxt = ST_BYPASS; // see [R11]
        end else if (drive_in.start_cmd && seq_en) begin
          state_nxt = ST_WAIT_REL;
        end
      end
      ST_WAIT_REL: begin
        if (!drive_in.start_cmd) begin
          state_nxt = ST_IDLE;
        end else if (drive_in.speed_cmd >= rel_freq_r
                     && drive_in.out_current >= rel_curr_r) begin
          state_nxt = ST_DETECT;
        end
      end
      ST_DETECT: begin
        // Both conditions must hold through the whole detect time
        if (!drive_in.start_cmd) begin
          state_nxt = ST_IDLE;
        end else if (drive_in.speed_cmd < rel_freq_r
                     || drive_in.out_current < rel_curr_r) begin
          state_nxt = ST_WAIT_REL;
        end else if (ms_r >= det_time_r) begin
          state_nxt = mode_fb ? ST_WAIT_FB : ST_START_HOLD; // see [R5]
        end
      end
      ST_WAIT_FB: begin
        if (fb) begin
          state_nxt = ST_START_HOLD; // see [R6]
        end
      end
      ST_START_HOLD: begin
        if (ms_r >= start_time_r) begin
          state_nxt = ST_RUN; // see [R6] see [R9]
        end
      end
      ST_RUN: begin
        if (drive_in.decel_active && drive_in.out_freq <= eng_freq_r) begin
          state_nxt = mode_fb ? ST_ENGAGE_WAIT : ST_STOP_HOLD; // see [R7]
        end
      end
      ST_ENGAGE_WAIT: begin
        if (!fb) begin
          state_nxt = ST_STOP_HOLD; // see [R8]
        end
      end
      ST_STOP_HOLD: begin
        if (ms_r >= stop_time_r) begin
          state_nxt = ST_IDLE; // see [R8] see [R10]
        end
      end
      ST_BYPASS: begin
        if (!drive_in.start_cmd && !bypass_req) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_FAULT: begin
        // Leaves only after software clears every fault
        if (fault_r == 7'h00) begin
          state_nxt = ST_IDLE; // see [R25]
        end
      end
    endcase
    if (any_fault && state_r != ST_BYPASS) begin
      state_nxt = ST_FAULT; // see [R13]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE; // see [R25]
    end else begin
      state_r <= state_nxt;
    end
  end

  // Request follows the target state so request and state change on the same edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      release_r <= 1'b0;
    end else begin
      release_r <= state_nxt inside {ST_WAIT_FB, ST_START_HOLD, ST_RUN}; // see [R13]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Unassigned output terminal rests low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      release_pin <= 1'b0;
    end else if (out_func_r == OUT_FUNC_POS) begin
      release_pin <= release_r; // see [R4]
    end else if (out_func_r == OUT_FUNC_NEG) begin
      release_pin <= !release_r; // see [R4]
    end else begin
      release_pin <= 1'b0;
    end
  end

  // Drive controls registered from the target state, seq_en and the select inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_out <= '0;
    end else begin
      drive_out.freq_hold <= state_nxt inside {ST_DETECT, ST_WAIT_FB, ST_START_HOLD};
      drive_out.output_enable <= !(state_nxt inside {ST_IDLE, ST_FAULT});
      drive_out.trip <= state_nxt == ST_FAULT;
      drive_out.sequence_active <= seq_en && state_nxt != ST_BYPASS;
      drive_out.auto_restart_enable <= !seq_en; // see [R22]
      drive_out.jog_accept <= jog_q;
      drive_out.second_setting_accept <= second_q;
      drive_out.third_setting_accept <= drive_in.third_setting_select;
    end
  end

endmodule

// >>> dv/brake_seq_monitor.sv
`timescale 1ns/100ps
module brake_seq_monitor
  import brake_seq_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire drive_status_s drive_in,
  input wire drive_ctrl_s drive_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // First step of every fault reaction
  sequence s_trip_on;
    $rose(drive_out.trip);
  endsequence
  // Output off and frequency not held
  sequence s_dead;
    !drive_out.output_enable && !drive_out.freq_hold;
  endsequence

  a_trip_kills_out: assert property (s_trip_on |-> ##[0:2] s_dead)
    else $error("output alive after trip");
  a_trip_stays_dead: assert property (
    drive_out.trip && $past(drive_out.trip) |-> s_dead)
    else $error("output back during trip");
  a_no_auto_restart: assert property (
    drive_out.sequence_active |-> !drive_out.auto_restart_enable)
    else $error("auto restart in brake mode");
  a_jog_blocked: assert property (
    drive_in.auto_accel_active [*2] |-> !drive_out.jog_accept)
    else $error("jog taken in auto ramp");
  a_second_blocked: assert property (
    drive_in.auto_accel_active [*2] |-> !drive_out.second_setting_accept)
    else $error("second select taken in auto ramp");
  a_hold_needs_seq: assert property (
    drive_out.freq_hold |-> drive_out.sequence_active)
    else $error("hold outside brake mode");
  a_hold_while_on: assert property (
    drive_out.freq_hold |-> drive_out.output_enable)
    else $error("hold with output off");
  a_clear_stays_off: assert property (
    $fell(drive_out.trip) |-> !drive_out.output_enable [*2])
    else $error("restart without new start");
endmodule

bind mechanical_brake_sequencer brake_seq_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .drive_in(drive_in), .drive_out(drive_out)
);

// >>> dv/brake_model.sv
`timescale 1ns/100ps
module brake_model (
  input wire logic hclk,
  input wire logic release_req,
  input wire logic [7:0] lag,
  input wire logic [1:0] fault_sel,
  output logic feedback_pin
);
  logic [7:0] cnt_r = 8'h00;
  logic open_r = 1'b0;

  // Armature follows the request after the lag
  always @(posedge hclk) begin
    if (release_req == open_r) begin
      cnt_r <= 8'h00;
    end else if (cnt_r >= lag) begin
      open_r <= release_req;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // Contact faults: 1 never closes, 2 welded closed
  always_comb begin
    case (fault_sel)
      2'h1: feedback_pin = 1'b0;
      2'h2: feedback_pin = 1'b1;
      default: feedback_pin = open_r;
    endcase
  end
endmodule

// >>> dv/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) show_fail(32'(g), 32'(e)); end
module tb;
  import brake_seq_pkg::*;
  localparam int MS_C = 10;
  localparam drive_status_s IDLE_IN = '{motor_stopped: 1'b1, default: '0};
  logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, feedback_pin, release_pin;
  logic [7:0] haddr, out_func, lag;
  logic [1:0] htrans, fsel;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, d, r;
  wire logic hready, req_lvl;
  drive_status_s drv;
  drive_ctrl_s dout;
  int n_fail, n_compared, seed, n;

  assign hready = hreadyout;
  // Request as the brake sees it
  assign req_lvl = (out_func == OUT_FUNC_NEG) ? ~release_pin : release_pin;

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  mechanical_brake_sequencer #(.MS_CYC(MS_C)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .drive_in(drv),
    .feedback_pin(feedback_pin), .release_pin(release_pin), .drive_out(dout)
  );
  brake_model u_brake (
    .hclk(hclk), .release_req(req_lvl), .lag(lag), .fault_sel(fsel),
    .feedback_pin(feedback_pin)
  );

  task automatic show_fail(input logic [31:0] g, input logic [31:0] e);
    n_fail++;
    $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
  endtask
  task automatic complete_run();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    $display("[FAIL] t=%0t wait bound used up", $time);
    complete_run();
  endtask
  // One AHB single; waits for hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    hsel <= 1'b1;
    htrans <= HT_NONSEQ;
    haddr <= a;
    hwrite <= w;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    htrans <= HT_IDLE;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 40);
    d = hrdata;
    if (k >= 40) hang();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h00000000);
  endtask
  function automatic logic probe(input int s);
    case (s)
      0: probe = req_lvl;
      1: probe = dout.freq_hold;
      2: probe = dout.output_enable;
      3: probe = dout.trip;
      default: probe = feedback_pin;
    endcase
  endfunction
  // Edges until the probe reads v
  task automatic wait_on(input int s, input logic v, input int lim);
    n = 0;
    while (probe(s) !== v) begin
      if (n >= lim) hang();
      n++;
      @(posedge hclk);
    end
  endtask
  // Tick phase unknown: one tick of slack
  task automatic chk_win(input int e);
    `CHK((n >= e - 2) && (n <= e + MS_C + 6), 1'b1)
  endtask
  task automatic cond_on();
    drv.start_cmd <= 1'b1;
    drv.motor_stopped <= 1'b0;
    drv.speed_cmd <= REL_FREQ_RST + {8'h00, 8'($random(seed))};
    drv.out_current <= REL_CURR_RST + {8'h00, 8'($random(seed))};
    drv.out_freq <= 16'h0064;
  endtask
  task automatic settle();
    drv <= IDLE_IN;
    repeat (5) @(posedge hclk);
  endtask
  task automatic go_run(input logic [31:0] mw);
    wr(MODE_OFS, mw);
    cond_on();
    wait_on(1, 1'b1, 200);
    wait_on(1, 1'b0, 400);
    drv.out_freq <= 16'h0BB8;
  endtask
  task automatic stop_run();
    drv.decel_active <= 1'b1;
    drv.out_freq <= ENG_FREQ_RST;
    wait_on(2, 1'b0, 400);
    settle();
  endtask
  task automatic run_seq(input logic [3:0] m, input logic [7:0] f);
    wr(TERM_OFS, {8'h00, f, 8'h00, IN_FUNC_FB});
    out_func = f;
    lag <= 8'(3 + ($unsigned($random(seed)) % 16));
    wr(MODE_OFS, {28'h0000000, m});
    cond_on();
    wait_on(0, 1'b1, 200);
    chk_win(3 * MS_C);
    `CHK(release_pin, f == OUT_FUNC_POS)
    if (m == SEQ_MODE_FB) wait_on(4, 1'b1, 100);
    wait_on(1, 1'b0, 200);
    chk_win(4 * MS_C);
    drv.decel_active <= 1'b1;
    drv.out_freq <= ENG_FREQ_RST;
    wait_on(0, 1'b0, 10);
    if (m == SEQ_MODE_FB) wait_on(4, 1'b0, 100);
    wait_on(2, 1'b0, 200);
    chk_win(5 * MS_C);
    settle();
  endtask
  // Trip, read faults, clear, expect idle
  task automatic expect_fault(input logic [6:0] mask, input int lim);
    wait_on(3, 1'b1, lim);
    repeat (3) @(posedge hclk);
    `CHK(req_lvl, 1'b0)
    rd(FLT_OFS);
    `CHK(d[14:8], mask)
    drv <= IDLE_IN;
    fsel <= 2'h0;
    wr(FLT_OFS, 32'h00007F00);
    repeat (3) @(posedge hclk);
    `CHK(dout.trip, 1'b0)
    `CHK(req_lvl, 1'b0)
  endtask

  initial begin
    {hsel, hwrite, haddr, hwdata, fsel} = '0;
    htrans = HT_IDLE;
    hsize = 3'h2;
    drv = IDLE_IN;
    out_func = OUT_FUNC_POS;
    lag = 8'h04;
    hresetn = 1'b0;
    seed = 85275;
    n_fail = 0;
    n_compared = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK(dout.auto_restart_enable, 1'b1)
    rd(FREQ_OFS);
    `CHK(d, {ENG_FREQ_RST, REL_FREQ_RST})
    wr(FREQ_OFS, 32'h006400C8);
    rd(FREQ_OFS);
    `CHK(d, {ENG_FREQ_RST, REL_FREQ_RST})
    wr(FREQ_OFS, 32'h012C012C);
    rd(FREQ_OFS);
    `CHK(d, 32'h012C012C)
    wr(FREQ_OFS, {ENG_FREQ_RST, REL_FREQ_RST});
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40);
    `CHK(d, 32'h00000000)
    rd(OVSP_OFS);
    `CHK(d[15:0], OVSP_OFF)
    wr(TIME_OFS, 32'h00040003);
    wr(STOP_OFS, 32'h00000005);
    $display("registers done");
    for (int o = 0; o < 4; o++) begin
      wr(MODE_OFS, {22'h000000, 2'(o), 8'h08});
      repeat (2) @(posedge hclk);
      `CHK(dout.sequence_active, o != 3)
      `CHK(dout.auto_restart_enable, o == 3)
    end
    for (int m = 0; m < 16; m++) begin
      wr(MODE_OFS, {28'h0000000, 4'(m)});
      repeat (2) @(posedge hclk);
      `CHK(dout.sequence_active, (m == 7) || (m == 8))
    end
    $display("mode select done");
    for (int i = 0; i < 4; i++) begin
      run_seq(i < 2 ? SEQ_MODE_NOFB : SEQ_MODE_FB, i[0] ? OUT_FUNC_NEG : OUT_FUNC_POS);
    end
    wr(TERM_OFS, {16'h0000, 8'h00, IN_FUNC_FB});
    out_func = 8'h00;
    go_run(32'h00000008);
    `CHK(release_pin, 1'b0)
    stop_run();
    wr(TERM_OFS, {8'h00, OUT_FUNC_POS, 8'h00, IN_FUNC_FB});
    out_func = OUT_FUNC_POS;
    $display("sequences done");
    wr(MODE_OFS, 32'h00000008);
    repeat (12) begin
      r = $random(seed);
      drv.jog <= r[0];
      drv.second_setting_select <= r[1];
      drv.auto_accel_active <= r[2];
      repeat (3) @(posedge hclk);
      `CHK(dout.jog_accept, r[0] & ~r[2])
      `CHK(dout.second_setting_accept, r[1] & ~r[2])
    end
    settle();
    $display("bypass done");
    go_run(32'h00000008);
    drv.decel_active <= 1'b1;
    drv.decel_abnormal <= 1'b1;
    repeat (100) @(posedge hclk);
    `CHK(dout.trip, 1'b0)
    drv.decel_abnormal <= 1'b0;
    stop_run();
    go_run(32'h00000018);
    drv.decel_active <= 1'b1;
    drv.decel_abnormal <= 1'b1;
    expect_fault(7'h02, 50);
    go_run(32'h00000008);
    drv.motor_stopped <= 1'b1;
    expect_fault(7'h04, 50);
    go_run(32'h00000007);
    fsel <= 2'h1;
    expect_fault(7'h20, 50);
    wr(MODE_OFS, 32'h00000008);
    drv.start_cmd <= 1'b1;
    expect_fault(7'h08, 21000);
    `CHK(n > 2000 * MS_C, 1'b1)
    fsel <= 2'h1;
    wr(MODE_OFS, 32'h00000007);
    cond_on();
    expect_fault(7'h10, 21000);
    `CHK(n > 2000 * MS_C, 1'b1)
    go_run(32'h00000007);
    fsel <= 2'h2;
    drv.decel_active <= 1'b1;
    drv.out_freq <= ENG_FREQ_RST;
    wait_on(0, 1'b0, 10);
    drv.motor_stopped <= 1'b1;
    expect_fault(7'h40, 21000);
    `CHK(n > 2000 * MS_C - 10, 1'b1)
    wr(MODE_OFS, 32'h00001000);
    drv.out_freq <= 16'h0064;
    drv.det_freq <= 16'h012C;
    repeat (50) @(posedge hclk);
    `CHK(dout.trip, 1'b0)
    wr(OVSP_OFS, 32'h000000C8);
    repeat (50) @(posedge hclk);
    `CHK(dout.trip, 1'b0)
    wr(OVSP_OFS, 32'h000000C7);
    expect_fault(7'h01, 50);
    $display("faults done");
    complete_run();
  end
endmodule
